// >>> rtl/plc_pkg.sv
// Constants and types shared by the port lock and low power config bank
package plc_pkg;
  localparam logic [15:0] ADDR_CAPTURE_CFG = 16'he706;
  localparam logic [15:0] ADDR_LP_MONITOR = 16'hec00;
  localparam logic [15:0] ADDR_SECOND_CTRL = 16'hec01;
  localparam logic [7:0] CAPTURE_CFG_RESET = 8'h00;
  localparam logic [7:0] LP_MONITOR_RESET = 8'h00;
  localparam logic [7:0] SECOND_CTRL_RESET = 8'h00;
  localparam logic [7:0] CAPTURE_CFG_MASK = 8'h3f;
  localparam logic [7:0] SECOND_CTRL_MASK = 8'h07;
  localparam int XFER_LSB = 3;
  localparam int STROBE_POL_BIT = 5;
  localparam int THRESH_LSB = 0;
  localparam int PERIOD_LSB = 3;
  localparam int EXT_REF_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int IRQ_MASK_BIT = 2;
  localparam logic [1:0] XFER_RESERVED = 2'h3;
  localparam logic [1:0] XFER_ALL = 2'h0;
  localparam int TOGGLES_TO_SPI = 3;
  localparam int CLK_HZ = 25000000;
  localparam int LINE_TIME_MS = 20;
  localparam int LINE_CYCLES = CLK_HZ / 1000 * LINE_TIME_MS;
  localparam logic [4:0] PERIOD_OFFSET_IRQ = 5'h0a;
  localparam logic [4:0] PERIOD_OFFSET_EXT = 5'h01;
  typedef enum logic [1:0] {PLC_PORT_I2C, PLC_PORT_SPI} plc_port_t;
endpackage : plc_pkg

// >>> rtl/plc_timer_if.sv
// Interface carrying the low power measurement period request and done
`timescale 1ns/1ps
interface plc_timer_if;
  logic start;
  logic [5:0] lines;
  logic done;
  modport ctrl (output start, output lines, input done);
  modport timer (input start, input lines, output done);
endinterface : plc_timer_if

// >>> rtl/plc_period_timer.sv
// Measurement period timer counting 20 ms line periods
`timescale 1ns/1ps
module plc_period_timer #(
  parameter int LINE_CYCLES = plc_pkg::LINE_CYCLES
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, active low
  plc_timer_if.timer tif // Period request and done
);
  logic [31:0] cyc_q, cyc_d;
  logic [5:0] left_q, left_d;
  logic run_q, run_d;
  logic done_q, done_d;
  always_comb begin
    cyc_d = cyc_q;
    left_d = left_q;
    run_d = run_q;
    done_d = 1'b0;
    if (tif.start) begin
      run_d = 1'b1;
      cyc_d = 32'h0;
      left_d = tif.lines;
    end else if (run_q) begin
      if (cyc_q == 32'(LINE_CYCLES - 1)) begin
        cyc_d = 32'h0;
        if (left_q <= 6'h1) begin
          run_d = 1'b0;
          done_d = 1'b1;
        end else begin
          left_d = left_q - 6'h1;
        end
      end else begin
        cyc_d = cyc_q + 32'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= 32'h0;
      left_q <= 6'h0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      left_q <= left_d;
      run_q <= run_d;
      done_q <= done_d;
    end
  end
  assign tif.done = done_q;
endmodule : plc_period_timer

// >>> rtl/plc_config_bank.sv
// Port lock and low power configuration register bank
`timescale 1ns/1ps
module plc_config_bank #(
  parameter bit HAS_LP_MONITOR = 1'b1,
  parameter int LINE_CYCLES = plc_pkg::LINE_CYCLES
) (
  input wire logic clk, // Clock 25 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic reg_wr, // Register write strobe, one cycle
  input wire logic reg_rd, // Register read strobe, one cycle
  input wire logic [15:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, registered
  output logic reg_hit, // Read address was mapped, registered
  input wire logic select_or_strobe_pin, // Raw select pin from host
  output logic strobe_active_level, // Level the strobe pin uses when active
  input wire logic capture_strobe_req, // Capture port strobe request
  output logic select_or_strobe_out, // Strobe output with polarity applied
  output logic [1:0] capture_transfer_select, // Effective transfer select
  output logic [2:0] low_power_current_threshold, // Threshold select
  input wire logic low_power_monitor_mode, // Device in low power monitor mode
  input wire logic lp_measure_start, // Start interrupt variant measurement
  output logic lp_measure_done, // Measurement period over, one cycle
  output logic external_reference_select, // 1 selects external reference
  input wire logic first_irq_req, // First interrupt request, active high
  output logic first_interrupt_pin_n, // First interrupt pin, active low
  output logic spi_active, // Host port is SPI
  output logic port_locked // Host port choice locked
);
  logic [7:0] cap_q, cap_d;
  logic [7:0] lpm_q, lpm_d;
  logic [7:0] ctl_q, ctl_d;
  logic [7:0] rdata_q, rdata_d;
  logic hit_q, hit_d;
  plc_pkg::plc_port_t port_q, port_d;
  logic lock_q, lock_d;
  logic [1:0] tog_q, tog_d;
  logic ss_m_q, ss_s_q, ss_prev_q;
  logic ss_edge;
  logic lpm_en;
  plc_timer_if tif ();

  assign lpm_en = HAS_LP_MONITOR;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_m_q <= 1'b1;
      ss_s_q <= 1'b1;
      ss_prev_q <= 1'b1;
    end else begin
      ss_m_q <= select_or_strobe_pin;
      ss_s_q <= ss_m_q;
      ss_prev_q <= ss_s_q;
    end
  end
  assign ss_edge = ss_s_q ^ ss_prev_q;

  always_comb begin
    cap_d = cap_q;
    lpm_d = lpm_q;
    ctl_d = ctl_q;
    port_d = port_q;
    lock_d = lock_q;
    tog_d = tog_q;
    if (reg_wr) begin
      case (reg_addr)
        plc_pkg::ADDR_CAPTURE_CFG: cap_d = reg_wdata & plc_pkg::CAPTURE_CFG_MASK;
        plc_pkg::ADDR_LP_MONITOR: begin
          if (lpm_en) begin
            lpm_d = reg_wdata;
          end
        end
        plc_pkg::ADDR_SECOND_CTRL: begin
          ctl_d = reg_wdata & plc_pkg::SECOND_CTRL_MASK;
          if (port_q == plc_pkg::PLC_PORT_SPI) begin
            lock_d = 1'b1;
          end else if (reg_wdata[plc_pkg::LOCK_BIT]) begin
            lock_d = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Lock is never cleared except by reset, so mode changes keep it
    if (!lock_q && port_q == plc_pkg::PLC_PORT_I2C && ss_edge) begin
      if (tog_q == 2'(plc_pkg::TOGGLES_TO_SPI - 1)) begin
        port_d = plc_pkg::PLC_PORT_SPI;
        tog_d = 2'h0;
      end else begin
        tog_d = tog_q + 2'h1;
      end
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    hit_d = hit_q;
    if (reg_rd) begin
      hit_d = 1'b1;
      case (reg_addr)
        plc_pkg::ADDR_CAPTURE_CFG: rdata_d = cap_q;
        plc_pkg::ADDR_LP_MONITOR: begin
          rdata_d = lpm_en ? lpm_q : 8'h00;
          hit_d = lpm_en;
        end
        plc_pkg::ADDR_SECOND_CTRL: rdata_d = ctl_q;
        default: begin
          rdata_d = 8'h00;
          hit_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_q <= plc_pkg::CAPTURE_CFG_RESET;
      lpm_q <= plc_pkg::LP_MONITOR_RESET;
      ctl_q <= plc_pkg::SECOND_CTRL_RESET;
      port_q <= plc_pkg::PLC_PORT_I2C;
      lock_q <= 1'b0;
      tog_q <= 2'h0;
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end else begin
      cap_q <= cap_d;
      lpm_q <= lpm_d;
      ctl_q <= ctl_d;
      port_q <= port_d;
      lock_q <= lock_d;
      tog_q <= tog_d;
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  always_comb begin
    capture_transfer_select = cap_q[plc_pkg::XFER_LSB +: 2];
    if (capture_transfer_select == plc_pkg::XFER_RESERVED) begin
      capture_transfer_select = plc_pkg::XFER_ALL;
    end
  end

  assign strobe_active_level = cap_q[plc_pkg::STROBE_POL_BIT];
  assign select_or_strobe_out = capture_strobe_req ~^ strobe_active_level ? 1'b1 : 1'b0;
  assign low_power_current_threshold = lpm_q[plc_pkg::THRESH_LSB +: 3];
  assign external_reference_select = ctl_q[plc_pkg::EXT_REF_BIT];
  assign first_interrupt_pin_n =
      ~(first_irq_req & ~(low_power_monitor_mode & ctl_q[plc_pkg::IRQ_MASK_BIT]));
  assign spi_active = (port_q == plc_pkg::PLC_PORT_SPI);
  assign port_locked = lock_q;
  assign reg_rdata = rdata_q;
  assign reg_hit = hit_q;

  assign tif.start = lp_measure_start & lpm_en;
  assign tif.lines = {1'b0, lpm_q[plc_pkg::PERIOD_LSB +: 5]} + {1'b0, plc_pkg::PERIOD_OFFSET_IRQ};
  assign lp_measure_done = tif.done;

  plc_period_timer #(
    .LINE_CYCLES(LINE_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .tif(tif)
  );
endmodule : plc_config_bank

// >>> dv/plc_host_model.sv
// Host model that toggles the select pin three times on request
`timescale 1ns/1ps
module plc_host_model (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic go, // start toggles
  output logic pin // select pin, high after reset, low after three toggles
);
  logic [4:0] cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
      pin <= 1'b1;
    end else if (go) begin
      cnt_q <= 5'h18;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
      pin <= (cnt_q[2:0] == 3'h0) ? ~pin : pin;
    end
  end
endmodule : plc_host_model

// >>> dv/plc_config_bank_checker.sv
// Port checks for the config bank
`timescale 1ns/1ps
module plc_config_bank_checker (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [15:0] reg_addr, // address
  input wire logic [7:0] reg_wdata, // wdata
  input wire logic [7:0] reg_rdata, // rdata
  input wire logic reg_hit, // hit
  input wire logic strobe_active_level, // polarity
  input wire logic capture_strobe_req, // strobe req
  input wire logic select_or_strobe_out, // strobe out
  input wire logic [1:0] capture_transfer_select, // xfer
  input wire logic spi_active, // spi
  input wire logic port_locked // lock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_xfer_no_reserved: assert property (capture_transfer_select != 2'h3)
    else $error("reserved transfer code");
  a_strobe_pol: assert property (
    select_or_strobe_out == (strobe_active_level ~^ capture_strobe_req)) else $error("polarity");
  a_rd_reserved: assert property (
    reg_rd && reg_addr == 16'he706 |=> reg_hit && reg_rdata[7:6] == 2'h0) else $error("rsvd");
  a_rd_unmapped: assert property (
    reg_rd && !(reg_addr inside {16'he706, 16'hec00, 16'hec01}) |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read");
  a_lock_write: assert property (
    reg_wr && reg_addr == 16'hec01 && (reg_wdata[1] || spi_active) |=> port_locked)
    else $error("no lock");
  a_lock_sticky: assert property (port_locked |=> port_locked) else $error("unlock");
  a_spi_sticky: assert property (spi_active |=> spi_active) else $error("spi lost");
  a_spi_unlocked: assert property (
    $rose(spi_active) |-> $past(port_locked) == 1'b0) else $error("spi while locked");
endmodule : plc_config_bank_checker
bind plc_config_bank plc_config_bank_checker u_chk (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .reg_hit, .strobe_active_level, .capture_strobe_req,
  .select_or_strobe_out, .capture_transfer_select, .spi_active, .port_locked);

// >>> dv/testbench.sv
// Register and port lock tests for the config bank
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic low_power_monitor_mode = 1'b0, lp_measure_start = 1'b0;
  logic first_irq_req = 1'b0, capture_strobe_req = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [1:0] capture_transfer_select;
  logic [2:0] low_power_current_threshold;
  logic select_or_strobe_pin, reg_hit, strobe_active_level, select_or_strobe_out;
  logic lp_measure_done, external_reference_select, first_interrupt_pin_n;
  logic spi_active, port_locked;
  logic [7:0] rdata_nolp;
  logic hit_nolp;
  int bad_count = 0;
  int compares = 0;
  int n;
  always #20 clk = ~clk;
  plc_config_bank #(.LINE_CYCLES(4)) u_dut (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_hit, .select_or_strobe_pin, .strobe_active_level,
    .capture_strobe_req, .select_or_strobe_out, .capture_transfer_select,
    .low_power_current_threshold, .low_power_monitor_mode, .lp_measure_start,
    .lp_measure_done, .external_reference_select, .first_irq_req, .first_interrupt_pin_n,
    .spi_active, .port_locked);
  // Lower variant without the monitor register, sharing all stimulus
  plc_config_bank #(.HAS_LP_MONITOR(1'b0), .LINE_CYCLES(4)) u_dut_nolp (.clk, .rst_n,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata(rdata_nolp), .reg_hit(hit_nolp),
    .select_or_strobe_pin, .strobe_active_level(), .capture_strobe_req,
    .select_or_strobe_out(), .capture_transfer_select(), .low_power_current_threshold(),
    .low_power_monitor_mode, .lp_measure_start, .lp_measure_done(),
    .external_reference_select(), .first_irq_req, .first_interrupt_pin_n(), .spi_active(),
    .port_locked());
  plc_host_model u_host (.clk, .rst_n, .go, .pin(select_or_strobe_pin));
  task automatic test_done;
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, e)
    `CHK(reg_hit, h)
    @(posedge clk);
  endtask : rd
  task automatic toggles;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : toggles
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    test_done;
  end
  initial begin
    do_reset;
    rd(16'he706, 8'h00, 1'b1);
    rd(16'hec00, 8'h00, 1'b1);
    rd(16'hec01, 8'h00, 1'b1);
    rd(16'h1234, 8'h00, 1'b0);
    capture_strobe_req <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(16'he706, {2'b11, i[0], i[1:0], 3'b111});
      rd(16'he706, {2'b00, i[0], i[1:0], 3'b111}, 1'b1);
      `CHK(capture_transfer_select, (i == 3) ? 2'h0 : i[1:0])
      `CHK(select_or_strobe_out, i[0])
    end
    wr(16'hec00, 8'h15);
    rd(16'hec00, 8'h15, 1'b1);
    `CHK(rdata_nolp, 8'h00)
    `CHK(hit_nolp, 1'b0)
    `CHK(low_power_current_threshold, 3'h5)
    lp_measure_start <= 1'b1;
    @(posedge clk);
    lp_measure_start <= 1'b0;
    n = 0;
    while (lp_measure_done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    `CHK(n inside {48, 49}, 1'b1)
    // Host times the second-pin-only period itself; no done pulse without a start
    n = 0;
    repeat ((2 + 1) * 4) begin
      @(negedge clk);
      if (lp_measure_done !== 1'b0) n++;
    end
    `CHK(n, 0)
    @(posedge clk);
    wr(16'hec01, 8'hfd);
    rd(16'hec01, 8'h05, 1'b1);
    `CHK(external_reference_select, 1'b1)
    `CHK(port_locked, 1'b0)
    first_irq_req <= 1'b1;
    low_power_monitor_mode <= 1'b1;
    @(negedge clk);
    `CHK(first_interrupt_pin_n, 1'b1)
    @(posedge clk);
    low_power_monitor_mode <= 1'b0;
    @(negedge clk);
    `CHK(first_interrupt_pin_n, 1'b0)
    @(posedge clk);
    toggles;
    `CHK(spi_active, 1'b1)
    wr(16'hec01, 8'h00);
    `CHK(port_locked, 1'b1)
    low_power_monitor_mode <= 1'b1;
    repeat (2) @(posedge clk);
    low_power_monitor_mode <= 1'b0;
    @(posedge clk);
    `CHK(port_locked & spi_active, 1'b1)
    do_reset;
    wr(16'hec01, 8'h02);
    toggles;
    `CHK(spi_active, 1'b0)
    `CHK(port_locked, 1'b1)
    test_done;
  end
endmodule : testbench
